// [design/vcxo_pll_pkg.sv]
// Functional notes
// - Feedback chain select 0 uses the primary divider alone, 1 uses primary times secondary.
// - Bypass bit 0 runs the first-stage PLL, 1 disables and bypasses it, resetting to 0.
// - Polarity bit 0 selects positive tuning slope, 1 negative, matched by software to the oscillator.
// - While force-midpoint is 1 the tuning pin is held at half supply, and the bit resets to 1.
// - The five-bit pump code gives 50 uA times code plus one, resetting to 11000.
// - A power bit write takes effect only when the commit register is written later.
// - After startup the copy output is powered up although the power bit reads 0.
// - Once committed, power bit 0 powers the copy output down and 1 powers it up.
// - Style bit 0 selects low-swing differential, 1 emitter-coupled, resetting to 0.
// - After startup the copy output is emitter-coupled although the style bit reads 0, changing only on commit.
package vcxo_pll_pkg;
  localparam logic [7:0] ADDR_FEEDBACK_BYPASS = 8'h03;
  localparam logic [7:0] ADDR_PLL1_BYPASS     = 8'h0a;
  localparam logic [7:0] ADDR_PLL1_TUNING     = 8'h10;
  localparam logic [7:0] ADDR_OSC_COPY        = 8'h11;
  localparam logic [7:0] ADDR_OSC_AMP_PLL2    = 8'h12;
  localparam logic [7:0] ADDR_OUTPUT_COMMIT   = 8'h13;

  localparam int BIT_CHAIN_SELECT = 0;
  localparam int BIT_PLL1_BYPASS  = 0;
  localparam int BIT_POLARITY     = 7;
  localparam int BIT_FORCE_MID    = 6;
  localparam int BIT_POWER_ON     = 7;
  localparam int BIT_STYLE        = 6;

  localparam logic [7:0] MASK_FEEDBACK_BYPASS = 8'h81;
  localparam logic [7:0] MASK_PLL1_BYPASS     = 8'h01;
  localparam logic [7:0] MASK_PLL1_TUNING     = 8'hdf;
  localparam logic [7:0] MASK_OSC_COPY        = 8'hff;
  localparam logic [7:0] MASK_OSC_AMP_PLL2    = 8'h7f;

  localparam logic [7:0] RST_FEEDBACK_BYPASS = 8'h00;
  localparam logic [7:0] RST_PLL1_BYPASS     = 8'h00;
  localparam logic [7:0] RST_PLL1_TUNING     = 8'h58;
  localparam logic [7:0] RST_OSC_COPY        = 8'h00;
  localparam logic [7:0] RST_OSC_AMP_PLL2    = 8'h18;
  localparam logic [7:0] RST_OUTPUT_COMMIT   = 8'h00;

  localparam logic       RST_LIVE_POWER_ON = 1'b1;
  localparam logic       RST_LIVE_STYLE    = 1'b1;
  localparam logic [1:0] RST_LIVE_AMPLITUDE = 2'h3;

  typedef struct packed {
    logic       feedbackChainSelect;
    logic       pll1Bypass;
    logic       tuningPolarity;
    logic       forceMidpointTuning;
    logic [4:0] pll1PumpCurrentCode;
    logic       phaseOffsetEnable;
    logic [4:0] phaseOffset;
    logic [4:0] pll2PumpCurrentCode;
  } pll_ctrl_t;

  typedef struct packed {
    logic       oscCopyPowerOn;
    logic       oscCopySignalStyle;
    logic [1:0] oscCopyAmplitude;
  } copy_out_t;
endpackage

// [design/vcxo_pll_control_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module vcxo_pll_control_regs
  import vcxo_pll_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       resetn,
  // Register access port
  input  wire logic       regWrite,
  input  wire logic       regRead,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  output var  logic [7:0] regRdata,
  output var  logic       regRvalid,
  // Analog control
  output var  pll_ctrl_t  pllCtrl,
  output var  copy_out_t  copyOut
);
  logic [7:0] fbByp_r, fbByp_nxt;
  logic [7:0] pllByp_r, pllByp_nxt;
  logic [7:0] tune_r, tune_nxt;
  logic [7:0] copy_r, copy_nxt;
  logic [7:0] amp_r, amp_nxt;
  logic [7:0] commit_r, commit_nxt;
  copy_out_t  live_r, live_nxt;
  pll_ctrl_t  ctrl_nxt;
  logic [7:0] rdata_nxt;
  logic       rvalid_nxt;

  always_comb begin
    fbByp_nxt  = fbByp_r;
    pllByp_nxt = pllByp_r;
    tune_nxt   = tune_r;
    copy_nxt   = copy_r;
    amp_nxt    = amp_r;
    commit_nxt = commit_r;
    live_nxt   = live_r;
    rdata_nxt  = 8'h00;
    rvalid_nxt = regRead;
    if (regWrite) begin
      // Masks drop reserved bits
      if (regAddr == ADDR_FEEDBACK_BYPASS) begin
        fbByp_nxt = regWdata & MASK_FEEDBACK_BYPASS;
      end else if (regAddr == ADDR_PLL1_BYPASS) begin
        pllByp_nxt = regWdata & MASK_PLL1_BYPASS;
      end else if (regAddr == ADDR_PLL1_TUNING) begin
        tune_nxt = regWdata & MASK_PLL1_TUNING;
      end else if (regAddr == ADDR_OSC_COPY) begin
        copy_nxt = regWdata & MASK_OSC_COPY;
      end else if (regAddr == ADDR_OSC_AMP_PLL2) begin
        amp_nxt = regWdata & MASK_OSC_AMP_PLL2;
      end else if (regAddr == ADDR_OUTPUT_COMMIT) begin
        commit_nxt = regWdata;
        // Any value written commits the staged output settings
        live_nxt.oscCopyPowerOn     = copy_r[BIT_POWER_ON];
        live_nxt.oscCopySignalStyle = copy_r[BIT_STYLE];
        live_nxt.oscCopyAmplitude   = amp_r[6:5];
      end
    end
    if (regRead) begin
      if (regAddr == ADDR_FEEDBACK_BYPASS) begin
        rdata_nxt = fbByp_r;
      end else if (regAddr == ADDR_PLL1_BYPASS) begin
        rdata_nxt = pllByp_r;
      end else if (regAddr == ADDR_PLL1_TUNING) begin
        rdata_nxt = tune_r;
      end else if (regAddr == ADDR_OSC_COPY) begin
        rdata_nxt = copy_r;
      end else if (regAddr == ADDR_OSC_AMP_PLL2) begin
        rdata_nxt = amp_r;
      end else if (regAddr == ADDR_OUTPUT_COMMIT) begin
        rdata_nxt = commit_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_comb begin
    ctrl_nxt.feedbackChainSelect = fbByp_nxt[BIT_CHAIN_SELECT];
    ctrl_nxt.pll1Bypass          = pllByp_nxt[BIT_PLL1_BYPASS];
    ctrl_nxt.tuningPolarity      = tune_nxt[BIT_POLARITY];
    ctrl_nxt.forceMidpointTuning = tune_nxt[BIT_FORCE_MID];
    ctrl_nxt.pll1PumpCurrentCode = tune_nxt[4:0];
    ctrl_nxt.phaseOffsetEnable   = copy_nxt[5];
    ctrl_nxt.phaseOffset         = copy_nxt[4:0];
    ctrl_nxt.pll2PumpCurrentCode = amp_nxt[4:0];
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      fbByp_r   <= RST_FEEDBACK_BYPASS;
      pllByp_r  <= RST_PLL1_BYPASS;
      tune_r    <= RST_PLL1_TUNING;
      copy_r    <= RST_OSC_COPY;
      amp_r     <= RST_OSC_AMP_PLL2;
      commit_r  <= RST_OUTPUT_COMMIT;
      // Live output powered and emitter-coupled despite zero register bits
      live_r    <= '{RST_LIVE_POWER_ON, RST_LIVE_STYLE, RST_LIVE_AMPLITUDE};
      regRdata  <= 8'h00;
      regRvalid <= 1'b0;
      // Tuning pin forced to mid-supply from the first reset edge
      pllCtrl   <= '{RST_FEEDBACK_BYPASS[BIT_CHAIN_SELECT], RST_PLL1_BYPASS[BIT_PLL1_BYPASS],
                     RST_PLL1_TUNING[BIT_POLARITY], RST_PLL1_TUNING[BIT_FORCE_MID], RST_PLL1_TUNING[4:0],
                     RST_OSC_COPY[5], RST_OSC_COPY[4:0], RST_OSC_AMP_PLL2[4:0]};
      copyOut   <= '{RST_LIVE_POWER_ON, RST_LIVE_STYLE, RST_LIVE_AMPLITUDE};
    end else begin
      fbByp_r   <= fbByp_nxt;
      pllByp_r  <= pllByp_nxt;
      tune_r    <= tune_nxt;
      copy_r    <= copy_nxt;
      amp_r     <= amp_nxt;
      commit_r  <= commit_nxt;
      live_r    <= live_nxt;
      regRdata  <= rdata_nxt;
      regRvalid <= rvalid_nxt;
      pllCtrl   <= ctrl_nxt;
      copyOut   <= live_nxt;
    end
  end

  property p_copy_hold;
    @(posedge clk) disable iff (!resetn)
      (regWrite && regAddr == ADDR_OSC_COPY) |=> $stable(copyOut.oscCopyPowerOn);
  endproperty
  a_copy_hold: assert property (p_copy_hold) else $error("power changed without commit");

  property p_commit_power;
    @(posedge clk) disable iff (!resetn)
      (regWrite && regAddr == ADDR_OUTPUT_COMMIT) |=> (copyOut.oscCopyPowerOn == copy_r[BIT_POWER_ON]);
  endproperty
  a_commit_power: assert property (p_commit_power) else $error("commit did not apply power");

  property p_commit_style;
    @(posedge clk) disable iff (!resetn)
      (regWrite && regAddr == ADDR_OUTPUT_COMMIT) |=> (copyOut.oscCopySignalStyle == copy_r[BIT_STYLE]);
  endproperty
  a_commit_style: assert property (p_commit_style) else $error("commit did not apply style");

  property p_start_live;
    @(posedge clk) $rose(resetn) |-> copyOut.oscCopyPowerOn && copyOut.oscCopySignalStyle && !copy_r[7];
  endproperty
  a_start_live: assert property (p_start_live) else $error("startup output state wrong");

  property p_force_reset;
    @(posedge clk) $rose(resetn) |-> tune_r[BIT_FORCE_MID] && tune_r[4:0] == 5'h18 && pllCtrl.forceMidpointTuning;
  endproperty
  a_force_reset: assert property (p_force_reset) else $error("tuning reset value wrong");

  property p_reserved;
    @(posedge clk) disable iff (!resetn)
      regRvalid && $past(regAddr) == ADDR_PLL1_BYPASS |-> regRdata[7:1] == 7'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero");

  property p_bypass_out;
    @(posedge clk) disable iff (!resetn)
      (regWrite && regAddr == ADDR_PLL1_BYPASS) |=> pllCtrl.pll1Bypass == $past(regWdata[0]);
  endproperty
  a_bypass_out: assert property (p_bypass_out) else $error("bypass not applied");

  property p_chain_out;
    @(posedge clk) disable iff (!resetn)
      (regWrite && regAddr == ADDR_FEEDBACK_BYPASS) |=> pllCtrl.feedbackChainSelect == $past(regWdata[0]);
  endproperty
  a_chain_out: assert property (p_chain_out) else $error("chain select not applied");

  property p_tune_out;
    @(posedge clk) disable iff (!resetn)
      (regWrite && regAddr == ADDR_PLL1_TUNING) |=>
        pllCtrl.tuningPolarity == $past(regWdata[7]) && pllCtrl.pll1PumpCurrentCode == $past(regWdata[4:0]);
  endproperty
  a_tune_out: assert property (p_tune_out) else $error("tuning fields not applied");

  property p_force_out;
    @(posedge clk) disable iff (!resetn)
      (regWrite && regAddr == ADDR_PLL1_TUNING) |=> pllCtrl.forceMidpointTuning == $past(regWdata[BIT_FORCE_MID]);
  endproperty
  a_force_out: assert property (p_force_out) else $error("force midpoint not applied");

  property p_style_hold;
    @(posedge clk) disable iff (!resetn)
      (regWrite && regAddr == ADDR_OSC_COPY) |=> $stable(copyOut.oscCopySignalStyle);
  endproperty
  a_style_hold: assert property (p_style_hold) else $error("style changed without commit");

  property p_idle_hold;
    @(posedge clk) disable iff (!resetn)
      !(regWrite && regAddr == ADDR_OUTPUT_COMMIT) |=> $stable(copyOut);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("copy output moved without commit");

  property p_reserved_fb;
    @(posedge clk) disable iff (!resetn)
      regRvalid && $past(regAddr) == ADDR_FEEDBACK_BYPASS |-> regRdata[6:1] == 6'h00;
  endproperty
  a_reserved_fb: assert property (p_reserved_fb) else $error("feedback reserved bits not zero");

  property p_reserved_tune;
    @(posedge clk) disable iff (!resetn)
      regRvalid && $past(regAddr) == ADDR_PLL1_TUNING |-> regRdata[5] == 1'b0;
  endproperty
  a_reserved_tune: assert property (p_reserved_tune) else $error("tuning reserved bit not zero");

  property p_reserved_amp;
    @(posedge clk) disable iff (!resetn)
      regRvalid && $past(regAddr) == ADDR_OSC_AMP_PLL2 |-> regRdata[7] == 1'b0;
  endproperty
  a_reserved_amp: assert property (p_reserved_amp) else $error("amplitude reserved bit not zero");

  property p_unmapped;
    @(posedge clk) disable iff (!resetn)
      regRvalid && $past(regAddr) > ADDR_OUTPUT_COMMIT |-> regRdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_reset_style;
    @(posedge clk) $rose(resetn) |-> !copy_r[BIT_STYLE] && !pllByp_r[BIT_PLL1_BYPASS];
  endproperty
  a_reset_style: assert property (p_reset_style) else $error("style or bypass reset value wrong");
endmodule
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import vcxo_pll_pkg::*;
  logic       clk        = 1'b0;
  logic       resetn     = 1'b0;
  logic       regWrite   = 1'b0;
  logic       regRead    = 1'b0;
  logic [7:0] regAddr    = 8'h00;
  logic [7:0] regWdata   = 8'h00;
  logic [7:0] regRdata;
  logic       regRvalid;
  pll_ctrl_t  pllCtrl;
  copy_out_t  copyOut;
  int         mismatches = 0;
  int         n_tests    = 0;
  int         cycles     = 0;
  integer     seed       = 32'hc3a3_0b61;
  int         idx;
  logic [7:0] addrs [6]  = '{ADDR_FEEDBACK_BYPASS, ADDR_PLL1_BYPASS, ADDR_PLL1_TUNING, ADDR_OSC_COPY,
                             ADDR_OSC_AMP_PLL2, ADDR_OUTPUT_COMMIT};
  logic [7:0] masks [6]  = '{MASK_FEEDBACK_BYPASS, MASK_PLL1_BYPASS, MASK_PLL1_TUNING, MASK_OSC_COPY,
                             MASK_OSC_AMP_PLL2, 8'hff};
  logic [7:0] mdl [6]    = '{RST_FEEDBACK_BYPASS, RST_PLL1_BYPASS, RST_PLL1_TUNING, RST_OSC_COPY,
                             RST_OSC_AMP_PLL2, RST_OUTPUT_COMMIT};
  copy_out_t  liveExp    = 4'hf;

  vcxo_pll_control_regs vcxo_pll_control_regs_inst (.clk(clk), .resetn(resetn), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRvalid(regRvalid),
    .pllCtrl(pllCtrl), .copyOut(copyOut));

  always #25 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic pll_ctrl_t expPll();
    return {mdl[0][0], mdl[1][0], mdl[2][7], mdl[2][6], mdl[2][4:0], mdl[3][5], mdl[3][4:0], mdl[4][4:0]};
  endfunction

  // Model follows each write; only a commit moves the live copy-output state
  task automatic wr(input int i, input logic [7:0] d);
    @(negedge clk);
    regWrite = 1'b1;
    regAddr  = addrs[i];
    regWdata = d;
    @(negedge clk);
    regWrite = 1'b0;
    mdl[i]   = d & masks[i];
    if (i == 5) liveExp = {mdl[3][7], mdl[3][6], mdl[4][6:5]};
    check("pllCtrl", 32'(expPll()), 32'(pllCtrl));
    check("copyOut", 32'(liveExp), 32'(copyOut));
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRead = 1'b0;
    check("regRvalid", 32'h1, 32'(regRvalid));
    check("regRdata", 32'(exp), 32'(regRdata));
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    for (int i = 0; i < 6; i++) rd(addrs[i], mdl[i]);
    check("pllCtrl", 32'(expPll()), 32'(pllCtrl));
    check("copyOut", 32'h0000_000f, 32'(copyOut));
    rd(8'h20, 8'h00);
    $display("test reset_values done");
    // Walking ones reach every field at both levels and every reserved bit
    for (int i = 0; i < 5; i++) begin
      for (int b = 0; b < 8; b++) begin
        wr(i, 8'h01 << b);
        rd(addrs[i], mdl[i]);
      end
    end
    $display("test walking_ones done");
    wr(3, 8'h00);
    check("copyOut", 32'h0000_000f, 32'(copyOut));
    wr(5, 8'h5a);
    check("copyOut", 32'h0000_0000, 32'(copyOut));
    wr(3, 8'hc0);
    wr(4, 8'h40);
    wr(5, 8'h00);
    $display("test commit done");
    repeat (40) begin
      idx = $unsigned($random(seed)) % 6;
      wr(idx, 8'($random(seed)));
      rd(addrs[idx], mdl[idx]);
    end
    wr(2, 8'h18);
    $display("test random done");
    complete_run();
  end
endmodule
`default_nettype wire
